// File: hdl/lf_tick_if.sv
// Interface carrying the filtered low-frequency clock tick to the counter.
// Assumes both ends run on the system clock.
`default_nettype none
interface lf_tick_if;
  logic tick;
  logic level;
  modport source (output tick, output level);
  modport sink (input tick, input level);
endinterface : lf_tick_if
`default_nettype wire

// File: hdl/lf_tick_sync.sv
// Synchroniser and rising-edge detector for the 32.768 kHz clock pin.
// Assumes the pin is asynchronous to the system clock and much slower.
`default_nettype none
module lf_tick_sync (
  input wire logic clock,          // System clock
  input wire logic srst,           // Synchronous reset, active high
  input wire logic lfClockPin,     // Low-frequency clock from the pin
  lf_tick_if.source tickLink       // Filtered level and one-cycle tick
);
  logic sync1;
  logic sync2;
  logic sync3;
  logic level;
  logic agree;

  // A change only counts once the second and third stages agree, so one
  // metastable sample can never produce a tick.
  assign agree = (sync2 == sync3);
  assign tickLink.tick = agree && sync2 && !level;
  assign tickLink.level = level;

  always_ff @(posedge clock) begin
    if (srst) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      sync3 <= 1'b0;
      level <= 1'b0;
    end else begin
      sync1 <= lfClockPin;
      sync2 <= sync1;
      sync3 <= sync2;
      if (agree) begin
        level <= sync2;
      end
    end
  end

  tick_single_a: assert property (@(posedge clock) disable iff (srst)
    tickLink.tick |=> !tickLink.tick)
    else $error("low-frequency tick lasted more than one cycle");
endmodule : lf_tick_sync
`default_nettype wire

// File: hdl/sleep_timer_24bit.sv
// Contract
// - The count is 24 bits wide and steps by one on each 32.768 kHz clock cycle.
// - Counting starts when reset is released and never halts, with no way to stop it.
// - A compare event is seen whenever the count becomes equal to the compare value.
// - Each compare event sets the sleep compare flag of interrupt source 5.
// - The interrupt reaches the core only while the sleep interrupt enable is set.
// - The count runs in both sleep modes and its compare event wakes the device.
// - After reset the compare value is 0xFFFFF until software writes it.
// - The compare event is also given out as DMA trigger 9.
// - The count is read through three byte registers, high byte giving bits 23:16.
// - Middle and high reads return the count latched when the low byte was read.
// - A high byte write stages compare bits 23:16, committed by the low byte write.
// - The count serves as a time base for the MAC timer across sleep.
// - The middle byte reads latched bits 15:8 and a write stages compare bits 15:8.
// - The low byte reads bits 7:0 and a write sets compare bits 7:0 and commits.
//
// Top of the sleep timer: counter, compare logic and the three byte registers.
// Assumes a one-cycle read and write strobe bus from the core, and that the core
// holds the interrupt flag register and clears the flag through flagClear.
`default_nettype none
module sleep_timer_24bit (
  input wire logic clock,                          // System clock, 50 MHz
  input wire logic srst,                           // Synchronous reset, active high
  input wire logic lfClockPin,                     // 32.768 kHz clock input
  input wire logic [7:0] sfrAddr,                  // Register byte address
  input wire logic sfrWrite,                       // Write strobe, one cycle
  input wire logic sfrRead,                        // Read strobe, one cycle
  input wire logic [7:0] sfrWdata,                 // Write data
  output logic [7:0] sfrRdata,                     // Read data, valid after read
  output logic sfrHit,                             // Address is one of ours
  input wire logic sleepInterruptEnable,           // Enable bit of the sleep interrupt
  input wire logic flagClear,                      // Core clears the sleep compare flag
  input wire sleep_timer_pkg::power_mode_t powerMode, // Present power mode
  output logic sleepCompareFlag,                   // Sticky compare flag
  output logic interruptRequest,                   // Gated request to the core
  output logic dmaTrigger,                         // One-cycle DMA trigger pulse
  output logic wakeRequest,                        // One-cycle wake pulse in sleep
  output logic [23:0] macTimeBase,                 // Running count for the MAC timer
  output logic macTimeTick                         // One-cycle pulse per count step
);
  lf_tick_if tickLink ();

  lf_tick_sync tickSync (
    .clock(clock),
    .srst(srst),
    .lfClockPin(lfClockPin),
    .tickLink(tickLink.source)
  );

  logic [23:0] count;
  logic [23:0] compare;
  logic [7:0] stageHigh;
  logic [7:0] stageMiddle;
  logic [15:0] readLatch;
  logic compareEvent;
  logic tickDelayed;

  wire tick = tickLink.tick;
  wire lfLevel = tickLink.level;
  wire [23:0] countPlusOne = count + 24'h000001;
  wire selLow = (sfrAddr == sleep_timer_pkg::COUNT_LOW_ADDR);
  wire selMiddle = (sfrAddr == sleep_timer_pkg::COUNT_MIDDLE_ADDR);
  wire selHigh = (sfrAddr == sleep_timer_pkg::COUNT_HIGH_ADDR);
  wire readLow = sfrRead && selLow;
  wire writeLow = sfrWrite && selLow;
  wire writeMiddle = sfrWrite && selMiddle;
  wire writeHigh = sfrWrite && selHigh;
  // Equality is tested against the value the count is about to take.
  wire compareHit = tick && (countPlusOne == compare);
  wire inSleep = (powerMode == sleep_timer_pkg::LIGHT_SLEEP_MODE) ||
                 (powerMode == sleep_timer_pkg::DEEP_SLEEP_MODE);
  wire [7:0] readMux = selLow ? count[7:0] :
                       selMiddle ? readLatch[7:0] :
                       selHigh ? readLatch[15:8] :
                       8'h00;

  assign sfrHit = selLow || selMiddle || selHigh;
  assign interruptRequest = sleepCompareFlag && sleepInterruptEnable;
  assign dmaTrigger = compareEvent;
  assign macTimeBase = count;
  assign macTimeTick = tickDelayed;

  // The counter has no enable: it runs in every power mode and wraps silently.
  always_ff @(posedge clock) begin
    if (srst) begin
      count <= sleep_timer_pkg::COUNT_RESET;
    end else if (tick) begin
      count <= countPlusOne;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      compareEvent <= 1'b0;
      wakeRequest <= 1'b0;
      tickDelayed <= 1'b0;
    end else begin
      compareEvent <= compareHit;
      wakeRequest <= compareHit && inSleep;
      tickDelayed <= tick;
    end
  end

  // A compare in the same cycle as a clear keeps the flag set.
  always_ff @(posedge clock) begin
    if (srst) begin
      sleepCompareFlag <= 1'b0;
    end else if (compareHit) begin
      sleepCompareFlag <= 1'b1;
    end else if (flagClear) begin
      sleepCompareFlag <= 1'b0;
    end
  end

  // Upper bytes are staged so that a three-write update never shows a mixed
  // compare value that could match by accident.
  always_ff @(posedge clock) begin
    if (srst) begin
      stageHigh <= sleep_timer_pkg::STAGE_RESET;
      stageMiddle <= sleep_timer_pkg::STAGE_RESET;
      compare <= sleep_timer_pkg::COMPARE_RESET;
    end else begin
      if (writeHigh) begin
        stageHigh <= sfrWdata;
      end
      if (writeMiddle) begin
        stageMiddle <= sfrWdata;
      end
      if (writeLow) begin
        compare <= {stageHigh, stageMiddle, sfrWdata};
      end
    end
  end

  // Reading the low byte freezes the upper bytes so software gets one coherent
  // sample even if the count steps between its reads.
  always_ff @(posedge clock) begin
    if (srst) begin
      readLatch <= sleep_timer_pkg::LATCH_RESET;
      sfrRdata <= sleep_timer_pkg::READ_RESET;
    end else begin
      if (readLow) begin
        readLatch <= count[23:8];
      end
      if (sfrRead) begin
        sfrRdata <= readMux;
      end
    end
  end

  sequence lowRead_s;
    sfrRead && selLow;
  endsequence

  sequence upperStaged_s;
    sfrWrite && (selHigh || selMiddle);
  endsequence

  count_step_a: assert property (@(posedge clock) disable iff (srst)
    tick |=> count == $past(countPlusOne))
    else $error("count did not step by one on a tick");

  count_hold_a: assert property (@(posedge clock) disable iff (srst)
    !tick |=> $stable(count))
    else $error("count changed without a tick");

  compare_hit_a: assert property (@(posedge clock) disable iff (srst)
    (tick && countPlusOne == compare) |=> compareEvent && count == $past(compare))
    else $error("compare match was missed");

  flag_set_a: assert property (@(posedge clock) disable iff (srst)
    compareEvent |-> sleepCompareFlag)
    else $error("compare event did not set the flag");

  flag_sticky_a: assert property (@(posedge clock) disable iff (srst)
    (sleepCompareFlag && !flagClear) |=> sleepCompareFlag)
    else $error("flag dropped without a clear");

  irq_gate_a: assert property (@(posedge clock) disable iff (srst)
    (compareEvent && !sleepInterruptEnable) |-> !interruptRequest)
    else $error("interrupt raised while disabled");

  wake_pulse_a: assert property (@(posedge clock) disable iff (srst)
    (compareHit && inSleep) |=> wakeRequest ##1 !wakeRequest)
    else $error("wake pulse missing or too long");

  compare_reset_a: assert property (@(posedge clock)
    $past(srst) |-> compare == sleep_timer_pkg::COMPARE_RESET)
    else $error("compare value wrong after reset");

  dma_pulse_a: assert property (@(posedge clock) disable iff (srst)
    dmaTrigger |-> $past(compareHit) ##1 !dmaTrigger)
    else $error("DMA trigger not a single pulse of a match");

  read_latch_a: assert property (@(posedge clock) disable iff (srst)
    lowRead_s |=> readLatch == $past(count[23:8]) && sfrRdata == $past(count[7:0]))
    else $error("low byte read did not latch the count");

  commit_a: assert property (@(posedge clock) disable iff (srst)
    writeLow |=> compare == {$past(stageHigh), $past(stageMiddle), $past(sfrWdata)})
    else $error("low byte write did not commit compare");

  stage_only_a: assert property (@(posedge clock) disable iff (srst)
    upperStaged_s |=> $stable(compare))
    else $error("upper byte write changed compare directly");

  wrap_a: assert property (@(posedge clock) disable iff (srst)
    (tick && count == 24'hffffff) |=> count == 24'h000000)
    else $error("count did not wrap to zero");

  tick_level_a: assert property (@(posedge clock) disable iff (srst)
    tick |=> lfLevel)
    else $error("filtered clock level did not follow a tick");

  wake_active_a: assert property (@(posedge clock) disable iff (srst)
    (compareHit && !inSleep) |=> !wakeRequest)
    else $error("wake pulse raised in active mode");

  rdata_hold_a: assert property (@(posedge clock) disable iff (srst)
    !sfrRead |=> $stable(sfrRdata))
    else $error("read data changed without a read");

  mac_tick_a: assert property (@(posedge clock) disable iff (srst)
    macTimeTick |-> count == $past(count) + 24'h000001)
    else $error("time base tick without a count step");
endmodule : sleep_timer_24bit
`default_nettype wire

// File: hdl/sleep_timer_pkg.sv
// Package for the 24-bit sleep timer: register offsets, reset values and widths.
// Assumes an 8-bit special function register bus with byte addresses.
`default_nettype none
package sleep_timer_pkg;
  localparam int CLOCK_HZ = 50_000_000;
  localparam int LF_CLOCK_HZ = 32_768;
  localparam int COUNT_WIDTH = 24;
  localparam logic [7:0] COUNT_LOW_ADDR = 8'h95;
  localparam logic [7:0] COUNT_MIDDLE_ADDR = 8'h96;
  localparam logic [7:0] COUNT_HIGH_ADDR = 8'h97;
  localparam logic [23:0] COUNT_RESET = 24'h000000;
  // The compare value after reset is only 20 bits of ones, not 24, so software
  // must write all three bytes before relying on a match in the upper range.
  localparam logic [23:0] COMPARE_RESET = 24'h0fffff;
  localparam logic [7:0] STAGE_RESET = 8'h00;
  localparam logic [7:0] READ_RESET = 8'h00;
  localparam logic [15:0] LATCH_RESET = 16'h0000;
  localparam int SLEEP_INTERRUPT_NUMBER = 5;
  localparam int SLEEP_DMA_TRIGGER_NUMBER = 9;

  typedef enum logic [1:0] {
    ACTIVE_POWER_MODE,
    LIGHT_SLEEP_MODE,
    DEEP_SLEEP_MODE,
    OTHER_POWER_MODE
  } power_mode_t;
endpackage : sleep_timer_pkg
`default_nettype wire

// File: tb/sfr_core_model.sv
// Model of the core side of the byte-wide special function register bus.
// Assumes one-cycle strobes that the timer takes on the rising clock edge.
`default_nettype none
module sfr_core_model (
  input wire logic clock,      // System clock
  output logic [7:0] sfrAddr,  // Register address
  output logic sfrWrite,       // Write strobe
  output logic sfrRead,        // Read strobe
  output logic [7:0] sfrWdata  // Write data
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    sfrAddr = 8'h00;
    sfrWrite = 1'b0;
    sfrRead = 1'b0;
    sfrWdata = 8'h00;
  end
  // Released address and data lines show the inverse so that a late sample of stale values is caught.
  task access(input logic wr, input logic [7:0] addr, input logic [7:0] data);
    @(posedge clock);
    sfrAddr <= addr;
    sfrWrite <= wr;
    sfrRead <= !wr;
    sfrWdata <= data;
    @(posedge clock);
    sfrWrite <= 1'b0;
    sfrRead <= 1'b0;
    sfrAddr <= ~addr;
    sfrWdata <= ~data;
  endtask : access
endmodule : sfr_core_model
`default_nettype wire

// File: tb/tb_sleep_timer_24bit.sv
// Self-checking bench for the sleep timer: count, latching, staging and compare events.
// Assumes the core model drives the register bus and the bench drives the slow clock pin.
`default_nettype none
module tb_sleep_timer_24bit;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic lfClockPin = 1'b0;
  logic sleepInterruptEnable = 1'b0;
  logic flagClear = 1'b0;
  sleep_timer_pkg::power_mode_t powerMode = sleep_timer_pkg::ACTIVE_POWER_MODE;
  logic [7:0] sfrAddr, sfrWdata, sfrRdata;
  logic sfrWrite, sfrRead, sfrHit, sleepCompareFlag, interruptRequest;
  logic dmaTrigger, wakeRequest, macTimeTick, readSeen = 1'b0;
  logic [23:0] macTimeBase, model, snap;
  logic [7:0] expected[$];
  int bad_count = 0, total_checks = 0, dmaPulses = 0, wakePulses = 0, tickPulses = 0;
  int n, k;
  always #10 clock = ~clock;
  sfr_core_model core (.clock(clock), .sfrAddr(sfrAddr), .sfrWrite(sfrWrite),
    .sfrRead(sfrRead), .sfrWdata(sfrWdata));
  sleep_timer_24bit uut (.clock(clock), .srst(srst), .lfClockPin(lfClockPin),
    .sfrAddr(sfrAddr), .sfrWrite(sfrWrite), .sfrRead(sfrRead), .sfrWdata(sfrWdata),
    .sfrRdata(sfrRdata), .sfrHit(sfrHit), .sleepInterruptEnable(sleepInterruptEnable),
    .flagClear(flagClear), .powerMode(powerMode), .sleepCompareFlag(sleepCompareFlag),
    .interruptRequest(interruptRequest), .dmaTrigger(dmaTrigger),
    .wakeRequest(wakeRequest), .macTimeBase(macTimeBase), .macTimeTick(macTimeTick));
  task check(input logic [23:0] seen, input logic [23:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
    end
  endtask : check
  task stop_test;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : stop_test
  // Each slow cycle is 4 system clocks high and 4 low, well above the filter's minimum.
  task ticks(input int num);
    repeat (num) begin
      @(posedge clock);
      lfClockPin <= 1'b1;
      repeat (4) @(posedge clock);
      lfClockPin <= 1'b0;
      repeat (3) @(posedge clock);
    end
    model = model + 24'(num);
    repeat (6) @(posedge clock);
  endtask : ticks
  task rd(input logic [7:0] addr, input logic [7:0] exp);
    expected.push_back(exp);
    core.access(1'b0, addr, 8'h00);
  endtask : rd
  task wr(input logic [7:0] addr, input logic [7:0] data);
    core.access(1'b1, addr, data);
  endtask : wr
  always @(posedge clock) begin
    readSeen <= sfrRead;
    if (sfrRead || sfrWrite) begin
      check(24'(sfrHit), 24'(sfrAddr inside {8'h95, 8'h96, 8'h97}));
    end
    if (readSeen) begin
      check(24'(sfrRdata), 24'(expected.pop_front()));
    end
    dmaPulses += int'(dmaTrigger === 1'b1);
    wakePulses += int'(wakeRequest === 1'b1);
    tickPulses += int'(macTimeTick === 1'b1);
  end
  initial begin
    #400000;
    bad_count++;
    stop_test();
  end
  initial begin
    void'($urandom(32'h9923));
    model = 24'h000000;
    repeat (12) @(posedge clock);
    srst <= 1'b0;
    rd(8'h95, 8'h00);
    rd(8'h96, 8'h00);
    rd(8'h97, 8'h00);
    wr(8'h94, 8'($urandom));
    rd(8'h94, 8'h00);
    $display("reset and unmapped test done");
    n = 256 + ($urandom % 64);
    ticks(n);
    snap = model;
    rd(8'h95, snap[7:0]);
    ticks(3);
    rd(8'h96, snap[15:8]);
    rd(8'h97, snap[23:16]);
    check(macTimeBase, model);
    check(24'(tickPulses), model);
    $display("count and latch test done");
    k = 2 + ($urandom % 4);
    snap = model + 24'(k);
    wr(8'h97, snap[23:16]);
    wr(8'h96, snap[15:8]);
    powerMode <= sleep_timer_pkg::DEEP_SLEEP_MODE;
    wr(8'h95, snap[7:0]);
    ticks(k);
    check(24'(dmaPulses), 24'h000001);
    check(24'(wakePulses), 24'h000001);
    check(24'(sleepCompareFlag), 24'h000001);
    check(24'(interruptRequest), 24'h000000);
    sleepInterruptEnable <= 1'b1;
    @(posedge clock);
    #1 check(24'(interruptRequest), 24'h000001);
    @(posedge clock);
    flagClear <= 1'b1;
    @(posedge clock);
    flagClear <= 1'b0;
    @(posedge clock);
    #1 check(24'(sleepCompareFlag), 24'h000000);
    ticks(3);
    check(24'(dmaPulses), 24'h000001);
    check(macTimeBase, model);
    $display("compare test done");
    powerMode <= sleep_timer_pkg::LIGHT_SLEEP_MODE;
    snap = model + 24'h000002;
    wr(8'h97, snap[23:16]);
    wr(8'h96, snap[15:8]);
    wr(8'h95, snap[7:0]);
    ticks(2);
    check(24'(dmaPulses), 24'h000002);
    check(24'(wakePulses), 24'h000002);
    powerMode <= sleep_timer_pkg::ACTIVE_POWER_MODE;
    snap = model + 24'h000001;
    wr(8'h97, snap[23:16]);
    wr(8'h96, snap[15:8]);
    wr(8'h95, snap[7:0]);
    ticks(1);
    check(24'(dmaPulses), 24'h000003);
    check(24'(wakePulses), 24'h000002);
    check(24'(sleepCompareFlag), 24'h000001);
    check(24'(interruptRequest), 24'h000001);
    check(macTimeBase, model);
    $display("power mode test done");
    stop_test();
  end
endmodule : tb_sleep_timer_24bit
`default_nettype wire
